/* rtl/switch_debounce.sv */
`timescale 1ns/10ps
// Synchronises one pin and accepts a new level after it holds steady.
module switch_debounce #(
  parameter int STABLE_CYC = 2500000
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic raw,
  output logic clean
);
  logic sync_a;
  logic sync_b;
  logic [31:0] count;

  // Two flip-flops bring the pin into the clock domain.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end

  // The output follows only after the level has been steady long enough.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count <= 32'h0;
      clean <= 1'b0;
    end else if (sync_b == clean) begin
      count <= 32'h0;
    end else if (count >= 32'(STABLE_CYC - 1)) begin
      count <= 32'h0;
      clean <= sync_b;
    end else begin
      count <= count + 32'h1;
    end
  end
endmodule

/* rtl/turn_module.sv */
`timescale 1ns/10ps
// Behaviour
// - One switch press flashes that side's lamp and indicator.
// - Both switches held together start four-way flashing.
// - Pressing the flashing side again stops flashing.
// - Pressing the opposite side moves flashing to that side.
// - After release count flashes; above speed threshold cancel at twenty.
// - At or below seven mph hold count; resume at eight mph.
// - Upright return after a lean cancels the turn within two seconds.
// - Upright reference calibrates each start after a quarter mile upright.
// - Four-way starts only with key on and security disarmed.
// - Four-way keeps running two hours after key off or arming.
// - Both switches again, key on and disarmed, end four-way flashing.
// - Disarm during four-way: dark second, one flash, dark second, resume.
// - Tip-over kills lamps, starter, and requests engine shutdown.
// - Shutdown latches until upright and a key off-then-on cycle.
// - Starter enabled only when the clutch or the neutral input shows safe.
// - Lamp over-current or short turns the lamp outputs off.
module turn_module #(
  parameter longint FLASH_HALF_CYC = turn_pkg::FLASH_HALF_CYC,
  parameter longint DEBOUNCE_CYC = turn_pkg::DEBOUNCE_CYC,
  parameter longint MS_CYC = turn_pkg::MS_CYC,
  parameter int HAZARD_RUN_S = turn_pkg::HAZARD_RUN_S
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic switch_left,
  input wire logic switch_right,
  input wire logic key_switch,
  input wire logic security_armed,
  input wire logic clutch_pulled,
  input wire logic in_neutral,
  input wire logic lamp_fault,
  input wire logic [7:0] speed_mph,
  input wire logic speed_valid,
  input wire logic tilt_lean,
  input wire logic tilt_over,
  input wire logic distance_tick,
  output logic lamp_left,
  output logic lamp_right,
  output logic indicator_left,
  output logic indicator_right,
  output logic starter_enable,
  output logic shutdown_request,
  output logic calibrated
);
  typedef enum {IDLE, TURN_LEFT, TURN_RIGHT, HAZARD, DARK1, CONFIRM, DARK2} mode_t;
  mode_t mode;
  logic sw_l, sw_r, sw_l_d, sw_r_d;
  logic key_s, key_a, arm_s, arm_a, clu_s, clu_a, neu_s, neu_a, flt_s, flt_a;
  logic lean_s, lean_a, over_s, over_a, key_d, arm_d;
  logic [31:0] flash_cnt;
  logic phase, flash_end;
  logic [31:0] ms_cnt;
  logic ms_tick, sec_tick;
  logic [9:0] ms_in_sec;
  logic [4:0] flashes;
  logic counting, speed_ok, leaned;
  logic [11:0] upright_ms;
  logic [13:0] hazard_s;
  logic [9:0] dark_ms;
  logic [9:0] cal_dist;
  logic tipped, key_seen_off, combo_done;
  logic press_l, press_r, both;

  // Debounced turn switches with period set by parameter.
  switch_debounce #(.STABLE_CYC(int'(DEBOUNCE_CYC))) deb_l (.clk_sys(clk_sys), .reset(reset),
    .raw(switch_left), .clean(sw_l));
  switch_debounce #(.STABLE_CYC(int'(DEBOUNCE_CYC))) deb_r (.clk_sys(clk_sys), .reset(reset),
    .raw(switch_right), .clean(sw_r));

  // Two-stage synchronisers for the key, security, clutch, neutral, lamp fault and tilt pins.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      {key_s, arm_s, clu_s, neu_s, flt_s, lean_s, over_s} <= 7'h00;
      {key_a, arm_a, clu_a, neu_a, flt_a, lean_a, over_a} <= 7'h00;
    end else begin
      {key_s, arm_s, clu_s, neu_s, flt_s, lean_s, over_s} <=
        {key_switch, security_armed, clutch_pulled, in_neutral, lamp_fault, tilt_lean, tilt_over};
      {key_a, arm_a, clu_a, neu_a, flt_a, lean_a, over_a} <=
        {key_s, arm_s, clu_s, neu_s, flt_s, lean_s, over_s};
    end
  end

  // Edge history of switches, key and security.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sw_l_d <= 1'b0;
      sw_r_d <= 1'b0;
      key_d <= 1'b0;
      arm_d <= 1'b0;
    end else begin
      sw_l_d <= sw_l;
      sw_r_d <= sw_r;
      key_d <= key_a;
      arm_d <= arm_a;
    end
  end

  assign both = sw_l && sw_r;
  assign press_l = sw_l && !sw_l_d && !sw_r;
  assign press_r = sw_r && !sw_r_d && !sw_l;

  // Millisecond and second enables.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ms_cnt <= 32'h0;
      ms_in_sec <= 10'h0;
    end else if (ms_tick) begin
      ms_cnt <= 32'h0;
      ms_in_sec <= sec_tick ? 10'h0 : ms_in_sec + 10'h1;
    end else begin
      ms_cnt <= ms_cnt + 32'h1;
    end
  end
  assign ms_tick = ms_cnt >= 32'(MS_CYC - 1);
  assign sec_tick = ms_tick && (ms_in_sec == 10'h3E7);

  // Flash phase generator; flash_end marks the close of one on-off cycle.
  always_ff @(posedge clk_sys) begin
    if (reset || mode == IDLE || mode == DARK1 || mode == DARK2) begin
      flash_cnt <= 32'h0;
      phase <= 1'b1;
    end else if (flash_cnt >= 32'(FLASH_HALF_CYC - 1)) begin
      flash_cnt <= 32'h0;
      phase <= !phase;
    end else begin
      flash_cnt <= flash_cnt + 32'h1;
    end
  end
  assign flash_end = (flash_cnt >= 32'(FLASH_HALF_CYC - 1)) && !phase;

  // Speed hysteresis from the serial speed value.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      speed_ok <= 1'b0;
    end else if (speed_valid) begin
      if (speed_mph <= turn_pkg::SPEED_HOLD_MPH) begin
        speed_ok <= 1'b0;
      end else if (speed_mph >= turn_pkg::SPEED_RESUME_MPH) begin
        speed_ok <= 1'b1;
      end
    end
  end

  // Upright calibration: distance travelled while upright on each start.
  always_ff @(posedge clk_sys) begin
    if (reset || (key_a && !key_d)) begin
      cal_dist <= 10'h0;
      calibrated <= 1'b0;
    end else if (lean_a) begin
      if (!calibrated) begin
        cal_dist <= 10'h0;
      end
    end else if (distance_tick && !calibrated) begin
      if (cal_dist >= 10'(turn_pkg::CAL_MILLIMILES - 1)) begin
        calibrated <= 1'b1;
      end
      cal_dist <= cal_dist + 10'h1;
    end
  end

  // Tip-over latch, released by upright plus key off then on.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tipped <= 1'b0;
      key_seen_off <= 1'b0;
    end else if (over_a) begin
      tipped <= 1'b1;
      key_seen_off <= 1'b0;
    end else if (tipped) begin
      if (!key_a) begin
        key_seen_off <= 1'b1;
      end else if (key_seen_off) begin
        tipped <= 1'b0;
      end
    end
  end

  // Main mode sequencer.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode <= IDLE;
      flashes <= 5'h0;
      counting <= 1'b0;
      leaned <= 1'b0;
      upright_ms <= 12'h0;
      hazard_s <= 14'h0;
      dark_ms <= 10'h0;
      combo_done <= 1'b0;
    end else begin
      if (!both) begin
        combo_done <= 1'b0;
      end
      case (mode)
        IDLE, TURN_LEFT, TURN_RIGHT: begin
          if (both && !combo_done && key_a && !arm_a) begin
            mode <= HAZARD;
            hazard_s <= 14'h0;
            combo_done <= 1'b1;
          end else if (press_l) begin
            mode <= (mode == TURN_LEFT) ? IDLE : TURN_LEFT;
            counting <= 1'b0;
            flashes <= 5'h0;
            leaned <= 1'b0;
          end else if (press_r) begin
            mode <= (mode == TURN_RIGHT) ? IDLE : TURN_RIGHT;
            counting <= 1'b0;
            flashes <= 5'h0;
            leaned <= 1'b0;
          end else if (mode != IDLE) begin
            if (!sw_l && !sw_r) begin
              counting <= 1'b1;
            end
            if (counting && speed_ok && flash_end) begin
              flashes <= flashes + 5'h1;
              if (flashes >= 5'(turn_pkg::CANCEL_FLASHES - 1)) begin
                mode <= IDLE;
              end
            end
            if (lean_a) begin
              leaned <= 1'b1;
              upright_ms <= 12'h0;
            end else if (leaned && ms_tick) begin
              upright_ms <= upright_ms + 12'h1;
              if (upright_ms >= 12'(turn_pkg::TILT_CANCEL_MS - 1)) begin
                mode <= IDLE;
              end
            end
          end
        end
        HAZARD: begin
          if (both && !combo_done && key_a && !arm_a) begin
            mode <= IDLE;
            combo_done <= 1'b1;
          end else if (arm_d && !arm_a) begin
            mode <= DARK1;
            dark_ms <= 10'h0;
          end else if (key_a && !arm_a) begin
            hazard_s <= 14'h0;
          end else if (sec_tick) begin
            hazard_s <= hazard_s + 14'h1;
            if (hazard_s >= 14'(HAZARD_RUN_S - 1)) begin
              mode <= IDLE;
            end
          end
        end
        DARK1, DARK2: begin
          if (ms_tick) begin
            dark_ms <= dark_ms + 10'h1;
            if (dark_ms >= 10'(turn_pkg::CONFIRM_DARK_MS - 1)) begin
              mode <= (mode == DARK1) ? CONFIRM : HAZARD;
              dark_ms <= 10'h0;
              hazard_s <= 14'h0;
            end
          end
        end
        CONFIRM: begin
          if (flash_end) begin
            mode <= DARK2;
          end
        end
        default: begin
          mode <= IDLE;
        end
      endcase
    end
  end

  // Lamp and indicator outputs, gated by tip-over and lamp faults.
  always_ff @(posedge clk_sys) begin
    if (reset || tipped || flt_a) begin
      lamp_left <= 1'b0;
      lamp_right <= 1'b0;
      indicator_left <= 1'b0;
      indicator_right <= 1'b0;
    end else begin
      lamp_left <= phase && (mode == TURN_LEFT || mode == HAZARD || mode == CONFIRM);
      lamp_right <= phase && (mode == TURN_RIGHT || mode == HAZARD || mode == CONFIRM);
      indicator_left <= phase && (mode == TURN_LEFT || mode == HAZARD || mode == CONFIRM);
      indicator_right <= phase && (mode == TURN_RIGHT || mode == HAZARD || mode == CONFIRM);
    end
  end

  // Starter permission and engine shutdown request.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      starter_enable <= 1'b0;
      shutdown_request <= 1'b0;
    end else begin
      starter_enable <= !tipped && key_a && (neu_a || clu_a);
      shutdown_request <= tipped;
    end
  end
endmodule

/* rtl/turn_pkg.sv */
package turn_pkg;
  // Clock rate in hertz.
  localparam longint CLK_HZ = 125000000;
  // Flash half period in milliseconds and its cycle count.
  localparam int FLASH_HALF_MS = 400;
  localparam longint FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  // Switch debounce time in milliseconds and its cycle count.
  localparam int DEBOUNCE_MS = 20;
  localparam longint DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  // Delay from upright return to cancellation, in milliseconds.
  localparam int TILT_CANCEL_MS = 1500;
  // Four-way unattended run, in seconds.
  localparam int HAZARD_RUN_S = 7200;
  // Disarm confirmation dark time, in milliseconds.
  localparam int CONFIRM_DARK_MS = 1000;
  // Flashes counted before automatic cancellation.
  localparam int CANCEL_FLASHES = 20;
  // Speed thresholds in mph.
  localparam logic [7:0] SPEED_HOLD_MPH = 8'h07;
  localparam logic [7:0] SPEED_RESUME_MPH = 8'h08;
  // Distance for calibration, in thousandths of a mile.
  localparam int CAL_MILLIMILES = 250;
  // Millisecond tick count.
  localparam longint MS_CYC = CLK_HZ / 1000;
endpackage

/* verification/engine_link.sv */
`timescale 1ns/10ps
// Engine controller stand-in that reports speed and travelled distance.
module engine_link (
  input wire logic clk_sys,
  input wire logic [7:0] speed_set,
  output logic [7:0] speed_mph,
  output logic speed_valid,
  output logic distance_tick
);
  logic [2:0] phase = 3'h0;
  initial speed_mph = 8'h00;
  initial speed_valid = 1'b0;
  initial distance_tick = 1'b0;
  // Speed frames every eight cycles; between frames the value is scrambled.
  always @(posedge clk_sys) begin
    phase <= phase + 3'h1;
    speed_valid <= (phase == 3'h0);
    speed_mph <= (phase == 3'h0) ? speed_set : ~speed_set;
    distance_tick <= (phase[1:0] == 2'h0) && (speed_set != 8'h00);
  end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic switch_left = 1'b0;
  logic switch_right = 1'b0;
  logic key_switch = 1'b0;
  logic security_armed = 1'b0;
  logic clutch_pulled = 1'b0;
  logic in_neutral = 1'b0;
  logic lamp_fault = 1'b0;
  logic tilt_lean = 1'b0;
  logic tilt_over = 1'b0;
  logic [7:0] speed_set = 8'h00;
  logic [7:0] speed_mph;
  logic speed_valid, distance_tick, lamp_left, lamp_right, indicator_left, indicator_right;
  logic starter_enable, shutdown_request, calibrated;
  int errors = 0;
  int checks = 0;
  int cycles = 0;

  engine_link u_link (.clk_sys(clk_sys), .speed_set(speed_set), .speed_mph(speed_mph),
    .speed_valid(speed_valid), .distance_tick(distance_tick));

  turn_module #(.FLASH_HALF_CYC(10), .DEBOUNCE_CYC(3), .MS_CYC(5), .HAZARD_RUN_S(3)) DUT (
    .clk_sys(clk_sys), .reset(reset), .switch_left(switch_left), .switch_right(switch_right),
    .key_switch(key_switch), .security_armed(security_armed), .clutch_pulled(clutch_pulled),
    .in_neutral(in_neutral), .lamp_fault(lamp_fault), .speed_mph(speed_mph),
    .speed_valid(speed_valid), .tilt_lean(tilt_lean), .tilt_over(tilt_over),
    .distance_tick(distance_tick), .lamp_left(lamp_left), .lamp_right(lamp_right),
    .indicator_left(indicator_left), .indicator_right(indicator_right),
    .starter_enable(starter_enable), .shutdown_request(shutdown_request),
    .calibrated(calibrated));

  // Free-running system clock.
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // Cuts a hung run short.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      results();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the chosen switches long enough to pass the debounce, then releases.
  task automatic press(input logic l, input logic r);
    switch_left = l;
    switch_right = r;
    cyc(20);
    switch_left = 1'b0;
    switch_right = 1'b0;
    cyc(20);
  endtask

  // Notes which of lamp left, lamp right, indicator left, indicator right lit over a flash.
  task automatic watch(input logic [3:0] exp, input logic [3:0] mask);
    logic [3:0] seen;
    seen = 4'h0;
    repeat (25) begin
      cyc(1);
      seen = seen | ({lamp_left, lamp_right, indicator_left, indicator_right} & mask);
    end
    chk({4'h0, seen}, {4'h0, exp & mask});
  endtask

  task automatic t_starter;
    in_neutral = 1'b1;
    cyc(10);
    chk({7'h00, starter_enable}, 8'h01);
    in_neutral = 1'b0;
    clutch_pulled = 1'b1;
    cyc(10);
    chk({7'h00, starter_enable}, 8'h01);
    clutch_pulled = 1'b0;
    cyc(10);
    chk({7'h00, starter_enable}, 8'h00);
    in_neutral = 1'b1;
  endtask

  task automatic t_manual;
    press(1'b1, 1'b0);
    watch(4'hA, 4'hF);
    press(1'b1, 1'b0);
    watch(4'h0, 4'hF);
    press(1'b1, 1'b0);
    press(1'b0, 1'b1);
    watch(4'h5, 4'hF);
    press(1'b0, 1'b1);
    watch(4'h0, 4'hF);
  endtask

  task automatic t_auto;
    speed_set = 8'h14;
    press(1'b1, 1'b0);
    cyc(360);
    watch(4'hA, 4'hF);
    cyc(3);
    watch(4'h0, 4'hF);
    chk({7'h00, calibrated}, 8'h00);
    cyc(600);
    chk({7'h00, calibrated}, 8'h01);
  endtask

  task automatic t_tilt;
    speed_set = 8'h07;
    press(1'b1, 1'b0);
    cyc(600);
    watch(4'hA, 4'hF);
    tilt_lean = 1'b1;
    cyc(100);
    tilt_lean = 1'b0;
    cyc(10000);
    watch(4'h0, 4'hF);
    press(1'b1, 1'b0);
    speed_set = 8'h08;
    cyc(330);
    watch(4'hA, 4'hF);
    cyc(100);
    watch(4'h0, 4'hF);
  endtask

  task automatic t_fault;
    press(1'b1, 1'b0);
    lamp_fault = 1'b1;
    cyc(5);
    watch(4'h0, 4'hC);
    lamp_fault = 1'b0;
    watch(4'h8, 4'hC);
    press(1'b1, 1'b0);
  endtask

  task automatic t_hazard;
    key_switch = 1'b0;
    cyc(10);
    press(1'b1, 1'b1);
    watch(4'h0, 4'hC);
    key_switch = 1'b1;
    security_armed = 1'b1;
    cyc(10);
    press(1'b1, 1'b1);
    watch(4'h0, 4'hC);
    security_armed = 1'b0;
    cyc(10);
    press(1'b1, 1'b1);
    watch(4'hF, 4'hF);
    press(1'b1, 1'b1);
    watch(4'h0, 4'hF);
    press(1'b1, 1'b1);
    key_switch = 1'b0;
    security_armed = 1'b1;
    cyc(100);
    watch(4'hF, 4'hC);
    security_armed = 1'b0;
    cyc(2000);
    watch(4'h0, 4'hC);
    cyc(2970);
    watch(4'hF, 4'hC);
    cyc(2000);
    watch(4'h0, 4'hC);
    cyc(3980);
    watch(4'hF, 4'hC);
    cyc(16000);
    watch(4'h0, 4'hC);
  endtask

  task automatic t_tip;
    key_switch = 1'b1;
    cyc(10);
    press(1'b1, 1'b0);
    tilt_over = 1'b1;
    cyc(10);
    watch(4'h0, 4'hC);
    chk({6'h00, starter_enable, shutdown_request}, 8'h01);
    key_switch = 1'b0;
    cyc(10);
    key_switch = 1'b1;
    cyc(10);
    chk({7'h00, shutdown_request}, 8'h01);
    tilt_over = 1'b0;
    cyc(20);
    chk({7'h00, shutdown_request}, 8'h01);
    key_switch = 1'b0;
    cyc(10);
    key_switch = 1'b1;
    cyc(10);
    chk({6'h00, starter_enable, shutdown_request}, 8'h02);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Reset, key on, then every scenario in turn.
  initial begin
    cyc(16);
    reset = 1'b0;
    key_switch = 1'b1;
    cyc(10);
    t_starter();
    t_manual();
    t_auto();
    t_tilt();
    t_fault();
    t_hazard();
    t_tip();
    results();
  end
endmodule

/* verification/turn_monitor.sv */
`timescale 1ns/10ps
// Watches the turn controller pins for safety and lamp behaviour.
module turn_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic key_switch,
  input wire logic clutch_pulled,
  input wire logic in_neutral,
  input wire logic lamp_fault,
  input wire logic tilt_over,
  input wire logic distance_tick,
  input wire logic lamp_left,
  input wire logic lamp_right,
  input wire logic starter_enable,
  input wire logic shutdown_request,
  input wire logic calibrated
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // A steady tip-over darkens the lamps, drops the starter and asks for shutdown.
  a_tip_lamps_dark: assert property (tilt_over [*6] |-> !lamp_left && !lamp_right)
    else $error("lamps lit while tipped over");
  a_tip_starter_off: assert property (tilt_over [*6] |-> !starter_enable)
    else $error("starter enabled while tipped over");
  a_tip_stop_request: assert property (tilt_over [*6] |-> shutdown_request)
    else $error("no shutdown request while tipped over");
  // The latch holds while the key stays on without an off period.
  a_shutdown_latch_hold: assert property (key_switch [*8] ##0 shutdown_request
    |=> shutdown_request)
    else $error("shutdown latch dropped with key held on");
  // A lamp fault gates both lamp outputs.
  a_fault_lamps_off: assert property (lamp_fault [*5] |-> !lamp_left && !lamp_right)
    else $error("lamps lit during lamp fault");
  // The starter needs neutral or the clutch, and the key on.
  a_starter_unsafe_off: assert property ((!clutch_pulled && !in_neutral) [*5]
    |-> !starter_enable)
    else $error("starter enabled in gear without clutch");
  a_starter_key_off: assert property (!key_switch [*5] |-> !starter_enable)
    else $error("starter enabled with key off");
  // Calibration completes only on a counted distance tick.
  a_cal_on_tick: assert property (!calibrated ##1 calibrated |->
    $past(distance_tick, 1) || $past(distance_tick, 2) || $past(distance_tick, 3))
    else $error("calibration completed without a distance tick");
  c_four_way: cover property (lamp_left && lamp_right);
  c_shutdown: cover property (shutdown_request);
  c_calibrated: cover property ($rose(calibrated));
endmodule

bind turn_module turn_monitor u_monitor (.clk_sys(clk_sys), .reset(reset),
  .key_switch(key_switch), .clutch_pulled(clutch_pulled), .in_neutral(in_neutral),
  .lamp_fault(lamp_fault), .tilt_over(tilt_over), .distance_tick(distance_tick),
  .lamp_left(lamp_left), .lamp_right(lamp_right), .starter_enable(starter_enable),
  .shutdown_request(shutdown_request), .calibrated(calibrated));
